// *** design/amp_defs.svh ***
`ifndef AMP_DEFS_SVH
`define AMP_DEFS_SVH
// Entry timeout in microseconds (plain default) and its cycle count at 20 MHz
`define AMP_CLK_MHZ 20
`define AMP_ENTRY_TIMEOUT_US 1000000
`define AMP_ENTRY_TIMEOUT_CYC (`AMP_ENTRY_TIMEOUT_US * `AMP_CLK_MHZ)
// Safe state dwell in nanoseconds (plain default) and its cycle count
`define AMP_SAFE_NS 1000
`define AMP_SAFE_CYC ((`AMP_SAFE_NS + 49) / 50)
// Command codes on the message channel
`define AMP_CMD_W 4
`define AMP_CMD_NONE 4'h0
`define AMP_CMD_DISC_ID 4'h1
`define AMP_CMD_DISC_SVID 4'h2
`define AMP_CMD_DISC_MODES 4'h3
`define AMP_CMD_ENTER 4'h4
`define AMP_CMD_EXIT 4'h5
`define AMP_CMD_DR_SWAP 4'h6
`define AMP_CMD_POWER_OK 4'h7
// Answer codes
`define AMP_ANS_ACK 2'h1
`define AMP_ANS_NAK 2'h2
`define AMP_ANS_ACCEPT 2'h3
`define AMP_ANS_REJECT 2'h0
// Packet targets
`define AMP_SOP 2'h0
`define AMP_SOP_PRIME 2'h1
`endif

// *** design/amp_pkg.sv ***
package amp_pkg;
  typedef enum logic [2:0] {
    amp_idle, amp_power, amp_ident, amp_svid, amp_modes, amp_safe_in, amp_active, amp_safe_out
  } amp_state_type;
  typedef enum logic [1:0] {amp_dr_reject, amp_dr_accept, amp_dr_hard_reset} amp_dr_type;
endpackage

// *** design/amp_timer.sv ***
`timescale 1ns/100ps
module amp_timer #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [WIDTH-1:0] limit,
  output logic expired
);
  logic [WIDTH-1:0] count;
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      count <= '0;
      expired <= 1'b0;
    end else if (count >= limit) begin
      expired <= 1'b1;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule

// *** design/amp_sync.sv ***
`timescale 1ns/100ps
module amp_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1, s2, s3;
  // Change counts once second and third stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          level[i] <= s3[i];
        end
      end
    end
  end
endmodule

// *** design/amp_policy.sv ***
`timescale 1ns/100ps
`include "amp_defs.svh"
// Functional notes
// - Explicit power contract before mode entry
// - Discovery order identity, SVIDs, modes, acknowledged
// - Billboard exposed after entry timeout expires
// - Enter Mode acknowledged, alternate signaling enabled
// - Mode held until exit, detach, reset, VBUS
// - Billboard may stay exposed after entry
// - Self-powered upstream prefers UFP, accepts swap
// - Bus-powered upstream stays UFP, rejects swaps
// - Downstream: self-powered dual-role, bus-powered sink
// - No host: prefer UFP, swap toward UFP
// - No host: accept swap to DFP, mark host-facing
// - Host present: remaining ports try source, DFP
// - Swap during active mode causes hard reset
// - No mode: initiate swap to DFP, reconnect
// - No mode: accept partner swap to DFP
// - Host detach: reconnect, resume no-host behaviour
// - Captive cable answers SOP and SOP prime
// - Safe state passed before entry and exit
module amp_policy #(
  parameter int unsigned ENTRY_TIMEOUT_CYC = `AMP_ENTRY_TIMEOUT_CYC,
  parameter logic [15:0] SUPPORTED_SVID = 16'h1234, // Arbitrary value
  parameter logic [2:0] SUPPORTED_MODE = 3'h1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] pin_in,
  input wire logic self_powered,
  input wire logic upstream_port,
  input wire logic flexible_role,
  input wire logic captive_cable,
  input wire logic host_present,
  input wire logic is_dfp,
  input wire logic msg_valid,
  input wire logic [3:0] msg_cmd,
  input wire logic [1:0] msg_target,
  input wire logic [15:0] msg_svid,
  input wire logic [2:0] msg_mode,
  output logic ans_valid,
  output logic [1:0] ans_code,
  output logic [3:0] ans_cmd,
  output logic [15:0] ans_data,
  output logic req_dr_swap,
  output logic req_hard_reset,
  output logic req_reconnect,
  output logic try_snk,
  output logic try_src,
  output logic sink_only,
  output logic drp_enable,
  output logic host_facing,
  output logic alt_active,
  output logic safe_state,
  output logic billboard
);
  localparam int SAFE_CYC = `AMP_SAFE_CYC;
  localparam int SAFE_W = $clog2(SAFE_CYC + 1);
  // Elaboration refuses counts the counters cannot serve
  if (ENTRY_TIMEOUT_CYC < 1) begin
    $error("ENTRY_TIMEOUT_CYC must be at least one");
  end
  if (SAFE_CYC < 1) begin
    $error("safe state dwell must be at least one cycle");
  end

  // Pins: attached, vbus present, hard reset seen, explicit contract
  logic [3:0] pins;
  amp_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .reset(reset),
    .pin(pin_in),
    .level(pins)
  );
  logic attached, vbus_ok, hard_reset_seen, contract_ok;
  assign attached = pins[0];
  assign vbus_ok = pins[1];
  assign hard_reset_seen = pins[2];
  assign contract_ok = pins[3];

  amp_pkg::amp_state_type state;
  logic entry_expired, safe_done, host_seen, target_ok;
  logic [SAFE_W-1:0] safe_cnt;
  logic exit_cond;

  // Hardware loss of link wins over any message
  assign exit_cond = !attached || !vbus_ok || hard_reset_seen;

  function automatic logic target_served(input logic [1:0] tgt, input logic captive);
    target_served = (tgt == `AMP_SOP) || (captive && tgt == `AMP_SOP_PRIME);
  endfunction
  assign target_ok = target_served(msg_target, captive_cable);

  // One decode for every accepted command
  function automatic logic cmd_hit(input logic valid, input logic ok, input logic [3:0] cmd,
                                   input logic [3:0] want);
    cmd_hit = valid && ok && (cmd == want);
  endfunction

  amp_timer #(.WIDTH(32)) u_entry (
    .clk(clk),
    .reset(reset),
    .run(attached && !alt_active),
    .limit(32'(ENTRY_TIMEOUT_CYC)),
    .expired(entry_expired)
  );

  // Mode sequencing
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= amp_pkg::amp_idle;
      safe_cnt <= '0;
    end else if (exit_cond && state != amp_pkg::amp_safe_out) begin
      state <= (state == amp_pkg::amp_active) ? amp_pkg::amp_safe_out : amp_pkg::amp_idle;
      safe_cnt <= '0;
    end else begin
      case (state)
        amp_pkg::amp_idle: begin
          if (attached) begin
            state <= amp_pkg::amp_power;
          end
        end
        amp_pkg::amp_power: begin
          if (contract_ok) begin
            state <= amp_pkg::amp_ident;
          end
        end
        amp_pkg::amp_ident: begin
          if (cmd_hit(msg_valid, target_ok, msg_cmd, `AMP_CMD_DISC_ID)) begin
            state <= amp_pkg::amp_svid;
          end
        end
        amp_pkg::amp_svid: begin
          if (cmd_hit(msg_valid, target_ok, msg_cmd, `AMP_CMD_DISC_SVID)) begin
            state <= amp_pkg::amp_modes;
          end
        end
        amp_pkg::amp_modes: begin
          if (cmd_hit(msg_valid, target_ok, msg_cmd, `AMP_CMD_ENTER) &&
              msg_svid == SUPPORTED_SVID && msg_mode == SUPPORTED_MODE) begin
            state <= amp_pkg::amp_safe_in;
          end
        end
        amp_pkg::amp_safe_in: begin
          if (safe_done) begin
            state <= amp_pkg::amp_active;
          end
        end
        amp_pkg::amp_active: begin
          if (cmd_hit(msg_valid, target_ok, msg_cmd, `AMP_CMD_EXIT)) begin
            state <= amp_pkg::amp_safe_out;
          end
        end
        amp_pkg::amp_safe_out: begin
          if (safe_done) begin
            state <= attached ? amp_pkg::amp_modes : amp_pkg::amp_idle;
          end
        end
        default: state <= amp_pkg::amp_idle;
      endcase
      safe_cnt <= (state == amp_pkg::amp_safe_in || state == amp_pkg::amp_safe_out) ?
                  safe_cnt + 1'b1 : '0;
    end
  end
  assign safe_done = (safe_cnt >= SAFE_W'(SAFE_CYC - 1));

  // Lanes held in safe state across entry and exit
  always_ff @(posedge clk) begin
    if (reset) begin
      safe_state <= 1'b1;
    end else begin
      safe_state <= (state != amp_pkg::amp_active) || exit_cond;
    end
  end

  // Loss of link drops the flag in the same cycle as the lanes
  always_ff @(posedge clk) begin
    if (reset) begin
      alt_active <= 1'b0;
    end else begin
      alt_active <= (state == amp_pkg::amp_active) && !exit_cond;
    end
  end

  // Billboard stays up once exposed; optional after entry
  always_ff @(posedge clk) begin
    if (reset || !attached) begin
      billboard <= 1'b0;
    end else if (entry_expired) begin
      billboard <= 1'b1;
    end else if (alt_active) begin
      billboard <= billboard;
    end
  end

  // Message answers
  logic ans_ok;
  logic [3:0] cmd_r;
  always_comb begin
    ans_ok = 1'b0;
    if (msg_cmd == `AMP_CMD_DISC_ID) begin
      ans_ok = state != amp_pkg::amp_idle && state != amp_pkg::amp_power;
    end else if (msg_cmd == `AMP_CMD_DISC_SVID || msg_cmd == `AMP_CMD_DISC_MODES) begin
      ans_ok = state == amp_pkg::amp_svid || state == amp_pkg::amp_modes ||
               state == amp_pkg::amp_active;
    end else if (msg_cmd == `AMP_CMD_ENTER) begin
      ans_ok = state == amp_pkg::amp_modes && msg_svid == SUPPORTED_SVID &&
               msg_mode == SUPPORTED_MODE && !exit_cond;
    end else if (msg_cmd == `AMP_CMD_EXIT) begin
      ans_ok = state == amp_pkg::amp_active;
    end
  end

  // Swap policy decision
  amp_pkg::amp_dr_type dr_resp;
  always_comb begin
    dr_resp = amp_pkg::amp_dr_reject;
    if (flexible_role && host_seen && !upstream_port) begin
      dr_resp = alt_active ? amp_pkg::amp_dr_hard_reset :
                (is_dfp ? amp_pkg::amp_dr_reject : amp_pkg::amp_dr_accept);
    end else if (flexible_role) begin
      dr_resp = amp_pkg::amp_dr_accept;
    end else if (upstream_port && !self_powered) begin
      dr_resp = amp_pkg::amp_dr_reject;
    end else if (upstream_port && is_dfp) begin
      dr_resp = amp_pkg::amp_dr_accept;
    end else if (!upstream_port && self_powered) begin
      dr_resp = amp_pkg::amp_dr_accept;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ans_valid <= 1'b0;
      ans_code <= `AMP_ANS_REJECT;
      ans_cmd <= `AMP_CMD_NONE;
      ans_data <= 16'h0000;
      req_hard_reset <= 1'b0;
      cmd_r <= `AMP_CMD_NONE;
    end else begin
      ans_valid <= 1'b0;
      req_hard_reset <= 1'b0;
      cmd_r <= msg_valid ? msg_cmd : `AMP_CMD_NONE;
      if (msg_valid && target_ok) begin
        ans_valid <= 1'b1;
        ans_cmd <= msg_cmd;
        ans_data <= (msg_cmd == `AMP_CMD_DISC_MODES) ? 16'(SUPPORTED_MODE) : SUPPORTED_SVID;
        if (msg_cmd == `AMP_CMD_DR_SWAP) begin
          if (dr_resp == amp_pkg::amp_dr_hard_reset) begin
            ans_valid <= 1'b0;
            req_hard_reset <= 1'b1;
          end else begin
            ans_code <= (dr_resp == amp_pkg::amp_dr_accept) ? `AMP_ANS_ACCEPT :
                        `AMP_ANS_REJECT;
          end
        end else begin
          ans_code <= ans_ok ? `AMP_ANS_ACK : `AMP_ANS_NAK;
        end
      end
    end
  end

  // Host tracking; detach forces a reconnect on a downstream port only
  logic attached_d;
  always_ff @(posedge clk) begin
    if (reset) begin
      host_seen <= 1'b0;
    end else begin
      host_seen <= host_present;
    end
  end

  // One pulse on the cycle the host goes away
  always_ff @(posedge clk) begin
    if (reset) begin
      req_reconnect <= 1'b0;
    end else begin
      req_reconnect <= host_seen && !host_present && !upstream_port;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      host_facing <= 1'b0;
    end else begin
      host_facing <= flexible_role && !host_present && attached && !is_dfp;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      attached_d <= 1'b0;
    end else begin
      attached_d <= attached;
    end
  end

  // Own swap requests, flexible role only: toward UFP with no host, toward DFP once a host is seen on a downstream port
  always_ff @(posedge clk) begin
    if (reset) begin
      req_dr_swap <= 1'b0;
    end else begin
      if (flexible_role && host_seen && !upstream_port) begin
        req_dr_swap <= attached && contract_ok && !alt_active && !is_dfp;
      end else if (flexible_role) begin
        req_dr_swap <= attached && contract_ok && is_dfp;
      end else begin
        req_dr_swap <= upstream_port && self_powered && attached && attached_d &&
                       contract_ok && is_dfp && 1'b0;
      end
    end
  end

  // Role preferences for the attach logic
  always_ff @(posedge clk) begin
    if (reset) begin
      try_snk <= 1'b0;
    end else begin
      try_snk <= upstream_port && self_powered && !flexible_role;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      try_src <= 1'b0;
    end else begin
      try_src <= flexible_role;
    end
  end

  // Sink-only in reset so an unresolved port never sources
  always_ff @(posedge clk) begin
    if (reset) begin
      sink_only <= 1'b1;
    end else begin
      sink_only <= !self_powered && !flexible_role;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      drp_enable <= 1'b0;
    end else begin
      drp_enable <= self_powered || flexible_role;
    end
  end
  logic unused_cmd;
  assign unused_cmd = ^cmd_r;
endmodule

// *** dv/amp_props.sv ***
`timescale 1ns/100ps
`include "amp_defs.svh"
module amp_props #(
  parameter int unsigned ENTRY_TIMEOUT_CYC = 100,
  parameter logic [15:0] SUPPORTED_SVID = 16'h1234, // Arbitrary value
  parameter logic [2:0] SUPPORTED_MODE = 3'h1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] pin_in,
  input wire logic self_powered,
  input wire logic upstream_port,
  input wire logic captive_cable,
  input wire logic msg_valid,
  input wire logic [3:0] msg_cmd,
  input wire logic [1:0] msg_target,
  input wire logic [15:0] msg_svid,
  input wire logic [2:0] msg_mode,
  input wire logic ans_valid,
  input wire logic [1:0] ans_code,
  input wire logic [3:0] ans_cmd,
  input wire logic req_hard_reset,
  input wire logic alt_active,
  input wire logic safe_state,
  input wire logic billboard
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] att_cnt;
  logic ex;
  logic ent;
  assign ex = msg_valid && (msg_cmd == `AMP_CMD_EXIT || msg_cmd == `AMP_CMD_DR_SWAP);
  assign ent = ans_valid && ans_cmd == `AMP_CMD_ENTER && ans_code == `AMP_ANS_ACK;
  // Saturates so a long attach never wraps into an early count
  always_ff @(posedge clk) begin
    if (reset || !pin_in[0]) att_cnt <= 32'h0;
    else if (att_cnt != 32'hffffffff) att_cnt <= att_cnt + 32'h1;
  end
  ans_cause_a: assert property (ans_valid |-> $past(msg_valid))
    else $error("answer without request");
  hard_once_a: assert property (req_hard_reset |=> !req_hard_reset)
    else $error("hard reset too long");
  hard_cause_a: assert property (req_hard_reset |->
    $past(msg_valid && msg_cmd == `AMP_CMD_DR_SWAP && alt_active))
    else $error("hard reset without swap in mode");
  enter_safe_a: assert property ($rose(alt_active) |-> $past(safe_state) && !safe_state)
    else $error("mode entered without safe state");
  mode_hold_a: assert property (alt_active && pin_in[2:0] == 3'b011 &&
    !ex && !$past(ex) && !$past(ex, 2) |=> alt_active)
    else $error("mode left without cause");
  enter_match_a: assert property (ent |->
    $past(msg_svid == SUPPORTED_SVID && msg_mode == SUPPORTED_MODE))
    else $error("wrong mode acknowledged");
  enter_power_a: assert property (ent |-> $past(pin_in[3], 4))
    else $error("entry without contract");
  target_skip_a: assert property (msg_valid && msg_target != `AMP_SOP &&
    !(captive_cable && msg_target == `AMP_SOP_PRIME) |=> !ans_valid)
    else $error("foreign target answered");
  bus_reject_a: assert property (ans_valid && ans_cmd == `AMP_CMD_DR_SWAP &&
    !self_powered && upstream_port |-> ans_code == `AMP_ANS_REJECT)
    else $error("bus powered swap accepted");
  bill_time_a: assert property ($rose(billboard) |->
    att_cnt >= ENTRY_TIMEOUT_CYC && att_cnt <= ENTRY_TIMEOUT_CYC + 8)
    else $error("billboard timing off");
endmodule
bind amp_policy amp_props #(.ENTRY_TIMEOUT_CYC(ENTRY_TIMEOUT_CYC),
  .SUPPORTED_SVID(SUPPORTED_SVID), .SUPPORTED_MODE(SUPPORTED_MODE)) u_props (
  .clk, .reset, .pin_in, .self_powered, .upstream_port, .captive_cable, .msg_valid,
  .msg_cmd, .msg_target, .msg_svid, .msg_mode, .ans_valid, .ans_code, .ans_cmd,
  .req_hard_reset, .alt_active, .safe_state, .billboard);

// *** dv/amp_host.sv ***
`timescale 1ns/100ps
module amp_host (
  input wire logic clk,
  output logic [3:0] pin_in,
  output logic msg_valid,
  output logic [3:0] msg_cmd,
  output logic [1:0] msg_target,
  output logic [15:0] msg_svid,
  output logic [2:0] msg_mode
);
  initial begin
    {pin_in, msg_valid, msg_cmd, msg_target, msg_svid, msg_mode} = '0;
  end
  // Attach first, VBUS next, contract last; settle time covers the sync
  task automatic power(input logic [3:0] lv);
    @(negedge clk);
    pin_in = lv;
    repeat (6) @(negedge clk);
  endtask
  // Fields inverted after release so stale data never looks current
  task automatic send(input logic [3:0] c, input logic [1:0] t, input logic [15:0] s,
    input logic [2:0] m);
    @(negedge clk);
    {msg_valid, msg_cmd, msg_target, msg_svid, msg_mode} = {1'b1, c, t, s, m};
    @(negedge clk);
    {msg_valid, msg_cmd, msg_target, msg_svid, msg_mode} = {1'b0, ~c, ~t, ~s, ~m};
  endtask
endmodule

// *** dv/alt_mode_entry_role_policy_tb.sv ***
`timescale 1ns/100ps
`include "amp_defs.svh"
module alt_mode_entry_role_policy_tb;
  localparam logic [15:0] SVID = 16'h1234; // Arbitrary value
  localparam logic [2:0] MODE = 3'h1;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic self_powered, upstream_port, flexible_role, captive_cable, host_present, is_dfp;
  logic msg_valid, ans_valid, req_dr_swap, req_hard_reset, req_reconnect, try_snk, try_src;
  logic sink_only, drp_enable, host_facing, alt_active, safe_state, billboard;
  logic [3:0] pin_in, msg_cmd, ans_cmd;
  logic [1:0] msg_target, ans_code;
  logic [15:0] msg_svid, ans_data, rs;
  logic [2:0] msg_mode;
  logic [3:0] cfg [4] = '{4'hd, 4'hc, 4'h0, 4'ha};
  int err_count = 0;
  int total_checks = 0;
  int stage = 0;
  bit alt_m = 0;
  always #25 clk = ~clk;
  amp_host h (.clk, .pin_in, .msg_valid, .msg_cmd, .msg_target, .msg_svid, .msg_mode);
  amp_policy #(.ENTRY_TIMEOUT_CYC(100), .SUPPORTED_SVID(SVID), .SUPPORTED_MODE(MODE)) dut (
    .clk, .reset, .pin_in, .self_powered, .upstream_port, .flexible_role, .captive_cable,
    .host_present, .is_dfp, .msg_valid, .msg_cmd, .msg_target, .msg_svid, .msg_mode,
    .ans_valid, .ans_code, .ans_cmd, .ans_data, .req_dr_swap, .req_hard_reset,
    .req_reconnect, .try_snk, .try_src, .sink_only, .drp_enable, .host_facing, .alt_active,
    .safe_state, .billboard);
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic await(ref logic s, input int lim);
    int n;
    n = 0;
    while (s !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > lim) begin
        err_count++;
        $display("mismatch at %0t: wait ran out", $time);
        summarize();
      end
    end
  endtask
  // Answer model; 4 stands for a hard reset instead of an answer
  function automatic int model(input logic [3:0] c, input logic [15:0] s, input logic [2:0] m);
    int need;
    need = (c == `AMP_CMD_DISC_ID) ? 0 : (c == `AMP_CMD_DISC_SVID) ? 1 : 2;
    if (c == `AMP_CMD_DR_SWAP) begin
      if (flexible_role && host_present && !upstream_port)
        return alt_m ? 4 : is_dfp ? `AMP_ANS_REJECT : `AMP_ANS_ACCEPT;
      if (flexible_role || (self_powered && !(upstream_port && !is_dfp))) return `AMP_ANS_ACCEPT;
      return `AMP_ANS_REJECT;
    end
    if (pin_in[3] !== 1'b1 || stage < need) return `AMP_ANS_NAK;
    if (c == `AMP_CMD_ENTER && (s != SVID || m != MODE)) return `AMP_ANS_NAK;
    if (need < 2) stage = need + 1;
    if (c == `AMP_CMD_ENTER) alt_m = 1;
    if (c == `AMP_CMD_EXIT) alt_m = 0;
    return `AMP_ANS_ACK;
  endfunction
  task automatic xfer(input logic [3:0] c, input logic [1:0] t, input logic [15:0] s,
    input logic [2:0] m);
    int e;
    int n;
    e = (t == `AMP_SOP || captive_cable && t == `AMP_SOP_PRIME) ? model(c, s, m) : -1;
    n = 0;
    h.send(c, t, s, m);
    while (ans_valid !== 1'b1 && req_hard_reset !== 1'b1 && n < 3) begin
      @(negedge clk);
      n++;
    end
    if (e < 0) check(ans_valid | req_hard_reset, 1'b0);
    else if (e == 4) check(req_hard_reset, 1'b1);
    else begin
      check(ans_valid, 1'b1);
      check(ans_code, e[1:0]);
      check(ans_cmd, c);
      if (e == `AMP_ANS_ACK && c == `AMP_CMD_DISC_SVID) check(ans_data, SVID);
      if (e == `AMP_ANS_ACK && c == `AMP_CMD_DISC_MODES)
        check(ans_data, 16'(MODE));
    end
  endtask
  initial begin
    void'($urandom(32'hfb37));
    {self_powered, upstream_port, flexible_role, is_dfp} = 4'h4;
    captive_cable = 1'($urandom);
    host_present = 1'b0;
    repeat (4) @(negedge clk);
    check(safe_state, 1'b1);
    check(alt_active | billboard, 1'b0);
    reset = 1'b0;
    $display("test reset done");
    h.power(4'h1);
    h.power(4'h3);
    check(billboard, 1'b0);
    xfer(`AMP_CMD_DISC_ID, `AMP_SOP, 16'h0, 3'h0);
    h.power(4'hb);
    xfer(`AMP_CMD_DISC_SVID, `AMP_SOP, 16'h0, 3'h0);
    xfer(`AMP_CMD_ENTER, `AMP_SOP, SVID, MODE);
    xfer(`AMP_CMD_DISC_ID, `AMP_SOP, 16'h0, 3'h0);
    xfer(`AMP_CMD_DISC_SVID, `AMP_SOP, 16'h0, 3'h0);
    for (int i = 0; i < 3; i++) begin
      rs = 16'($urandom);
      xfer(`AMP_CMD_DISC_MODES, `AMP_SOP, rs, 3'h0);
    end
    xfer(`AMP_CMD_DISC_MODES, `AMP_SOP_PRIME, SVID, 3'h0);
    xfer(`AMP_CMD_DISC_MODES, 2'h2, SVID, 3'h0);
    xfer(`AMP_CMD_DR_SWAP, `AMP_SOP, 16'h0, 3'h0);
    check(sink_only, 1'b1);
    $display("test discovery done");
    await(billboard, 200);
    check(billboard, 1'b1);
    $display("test billboard done");
    for (int i = 0; i < 4; i++) begin
      {self_powered, upstream_port, flexible_role, is_dfp} = cfg[i];
      repeat (3) @(negedge clk);
      xfer(`AMP_CMD_DR_SWAP, `AMP_SOP, 16'h0, 3'h0);
      check(drp_enable, self_powered);
      check(sink_only, !self_powered);
      if (upstream_port) check(try_snk, self_powered);
      if (flexible_role) check(host_facing, 1'b1);
    end
    host_present = 1'b1;
    captive_cable = 1'b1;
    repeat (3) @(negedge clk);
    check(try_src, 1'b1);
    check(req_dr_swap, 1'b1);
    // Host keeps DFP and refuses, so the request must stand
    repeat (2) @(negedge clk);
    check(req_dr_swap, 1'b1);
    xfer(`AMP_CMD_DR_SWAP, `AMP_SOP, 16'h0, 3'h0);
    rs = 16'($urandom) | 16'h8000;
    xfer(`AMP_CMD_ENTER, `AMP_SOP, rs, MODE);
    for (int k = 0; k < 2; k++) begin
      xfer(`AMP_CMD_ENTER, `AMP_SOP_PRIME, SVID, MODE);
      check(safe_state, 1'b1);
      await(alt_active, 40);
      check(billboard, 1'b1);
      if (k == 0) begin
        xfer(`AMP_CMD_EXIT, `AMP_SOP, SVID, MODE);
        repeat (2) @(negedge clk);
        check(alt_active, 1'b0);
        repeat (25) @(negedge clk);
      end
    end
    xfer(`AMP_CMD_DR_SWAP, `AMP_SOP, 16'h0, 3'h0);
    h.power(4'hf);
    alt_m = 0;
    check(alt_active, 1'b0);
    h.power(4'hb);
    host_present = 1'b0;
    await(req_reconnect, 10);
    check(req_reconnect, 1'b1);
    $display("test roles done");
    summarize();
  end
endmodule
